// File: rtl/fch_pkg.sv
// constants, field layout and carrier types for the front-end and hop control block
// assumes an 8-bit register map reached as aligned 32-bit words
package fch_pkg;
	// --------------------------------
	// register indices (byte address = 4 * index)
	// --------------------------------
	localparam logic [6:0] IDX_MAIN   = 7'h00;
	localparam logic [6:0] IDX_INTF   = 7'h01;
	localparam logic [6:0] IDX_FA2    = 7'h04;
	localparam logic [6:0] IDX_FA1    = 7'h05;
	localparam logic [6:0] IDX_FA0    = 7'h06;
	localparam logic [6:0] IDX_FB2    = 7'h08;
	localparam logic [6:0] IDX_FB1    = 7'h09;
	localparam logic [6:0] IDX_FB0    = 7'h0a;
	localparam logic [6:0] IDX_LOCK   = 7'h15;
	localparam logic [6:0] IDX_OVR1   = 7'h21;
	localparam logic [6:0] IDX_OVR2   = 7'h22;
	localparam logic [6:0] IDX_OVR3   = 7'h23;
	localparam logic [6:0] IDX_RES1   = 7'h45;
	localparam logic [6:0] IDX_RES2   = 7'h46;
	localparam logic [6:0] IDX_RES3   = 7'h47;
	// --------------------------------
	// field positions
	// --------------------------------
	localparam int MAIN_CHAN_SEL  = 6;
	localparam int TX_POL_BIT     = 0;
	localparam int RX_POL_BIT     = 1;
	localparam int TX_FOLLOW_BIT  = 2;
	localparam int RX_FOLLOW_BIT  = 3;
	localparam int OSC_ARR_EN_BIT = 5;
	localparam int PUMP_EN_BIT    = 6;
	localparam int OSC_CAL_EN_BIT = 6;
	localparam logic [3:0] LSEL_LOW  = 4'h0;
	localparam logic [3:0] LSEL_HIGH = 4'h1;
	localparam logic [3:0] LSEL_LOCK = 4'h2;
	localparam logic [7:0] REG_RST   = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// --------------------------------
	// carrier types
	// --------------------------------
	typedef struct packed {
		logic [3:0] pump_current;
		logic [4:0] osc_array;
		logic [5:0] osc_cal_current;
	} fch_cal_t;
	typedef struct packed {
		logic [23:0] freq;
		fch_cal_t    cal;
	} fch_synth_t;
endpackage

// File: rtl/fch_ctrl.sv
// front-end enable pins, lock pin and channel-hop synthesizer control
// assumes an axi4-lite master on ref_clk, amplifier states on the same clock
// How it works
// R1: polarity bits set active level of tx and rx amplifier enable pins
// R2: tx follow set: pin active exactly while internal power amplifier is on
// R3: rx follow set: pin active exactly while internal low-noise amplifier is on
// R4: follow clear: pin statically shows its polarity bit, a general output
// R5: lock select 0000 drives lock pin low, 0001 drives it high
// R6: two frequency sets; idle set writable while selected one drives synth
// R7: main bit 6 picks the active set; writing it hops channel
// R8: override fields and enables live in override registers one to three
// R9: host saves calibration results read from result registers one to three
// R10: host may reuse one calibration current value for all channels
// R11: host writes channel select first, then override values and enables
// R12: host turns amplifier off before hop, checks lock before turning on
// R13: host clears all override enables before any new calibration
// R14: set override enable substitutes the forced value for the calibration result
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module fch_ctrl #(
	parameter int ADDR_W = 12
) (
	input  wire logic                ref_clk,                // 40 mhz clock
	input  wire logic                rst,                    // sync reset, high
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,           // write address
	input  wire logic                s_axi_awvalid,          // write address valid
	output logic                     s_axi_awready,          // write address ready
	input  wire logic [31:0]         s_axi_wdata,            // write data
	input  wire logic [3:0]          s_axi_wstrb,            // write strobes
	input  wire logic                s_axi_wvalid,           // write data valid
	output logic                     s_axi_wready,           // write data ready
	output logic [1:0]               s_axi_bresp,            // write response
	output logic                     s_axi_bvalid,           // write response valid
	input  wire logic                s_axi_bready,           // write response ready
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,           // read address
	input  wire logic                s_axi_arvalid,          // read address valid
	output logic                     s_axi_arready,          // read address ready
	output logic [31:0]              s_axi_rdata,            // read data
	output logic [1:0]               s_axi_rresp,            // read response
	output logic                     s_axi_rvalid,           // read data valid
	input  wire logic                s_axi_rready,           // read data ready
	input  wire logic                int_pa_on,              // internal power amp on
	input  wire logic                int_lna_on,             // internal rx amp on
	input  wire logic                pll_lock_in,            // async synth lock level
	input  wire fch_pkg::fch_cal_t   cal_result_in,          // calibration engine results
	output logic                     ext_amp_enable_out,     // external tx amp enable
	output logic                     ext_rx_amp_enable_out,  // external rx amp enable
	output logic                     lock_out,               // lock pin
	output fch_pkg::fch_synth_t      synth_ctrl              // frequency and calibration
);
	// --------------------------------
	// state
	// --------------------------------
	typedef struct packed {
		logic [7:0]  main_reg;
		logic [7:0]  intf_reg;
		logic [7:0]  lock_reg;
		logic [7:0]  override_reg_one;
		logic [7:0]  override_reg_two;
		logic [7:0]  override_reg_three;
		logic [23:0] channel_freq_set_first;
		logic [23:0] channel_freq_set_second;
		logic        aw_hold;
		logic [6:0]  aw_idx;
		logic        aw_bad;
		logic        w_hold;
		logic [7:0]  w_byte;
		logic        w_lane0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [7:0]  rdata;
		logic [2:0]  lock_sync;
		logic        lock_filt;
		logic        amp_o;
		logic        rx_amp_o;
		logic        lock_o;
		fch_pkg::fch_synth_t synth;
	} fch_state_t;

	fch_state_t s_ff;
	fch_state_t nxt_s;

	function automatic logic is_mapped(input logic [6:0] idx);
		unique case (idx)
			fch_pkg::IDX_MAIN, fch_pkg::IDX_INTF, fch_pkg::IDX_LOCK,
			fch_pkg::IDX_FA2, fch_pkg::IDX_FA1, fch_pkg::IDX_FA0,
			fch_pkg::IDX_FB2, fch_pkg::IDX_FB1, fch_pkg::IDX_FB0,
			fch_pkg::IDX_OVR1, fch_pkg::IDX_OVR2, fch_pkg::IDX_OVR3,
			fch_pkg::IDX_RES1, fch_pkg::IDX_RES2, fch_pkg::IDX_RES3:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		return (a[ADDR_W-1:9] == '0) && (a[1:0] == 2'h0) && is_mapped(a[8:2]);
	endfunction

	logic       aw_fire;
	logic       w_fire;
	logic       ar_fire;
	logic       have_aw;
	logic       have_w;
	logic [6:0] wr_idx;
	logic [6:0] rd_idx;
	logic       wr_ok;

	assign s_axi_awready = !s_ff.aw_hold && !s_ff.bvalid;
	assign s_axi_wready  = !s_ff.w_hold && !s_ff.bvalid;
	assign s_axi_arready = !s_ff.rvalid;
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire  = s_axi_wvalid && s_axi_wready;
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign have_aw = s_ff.aw_hold || aw_fire;
	assign have_w  = s_ff.w_hold || w_fire;
	assign wr_idx  = s_ff.aw_hold ? s_ff.aw_idx : s_axi_awaddr[8:2];
	assign wr_ok   = s_ff.aw_hold ? !s_ff.aw_bad : addr_ok(s_axi_awaddr);
	assign rd_idx  = s_axi_araddr[8:2];

	// --------------------------------
	// next state
	// --------------------------------
	always_comb
	begin
		logic [7:0] wb;
		logic       wl;
		logic       tx_pol;
		logic       rx_pol;
		wb = s_ff.w_hold ? s_ff.w_byte : s_axi_wdata[7:0];
		wl = s_ff.w_hold ? s_ff.w_lane0 : s_axi_wstrb[0];
		tx_pol = s_ff.intf_reg[fch_pkg::TX_POL_BIT];
		rx_pol = s_ff.intf_reg[fch_pkg::RX_POL_BIT];
		nxt_s = s_ff;
		if (aw_fire)
		begin
			nxt_s.aw_hold = 1'b1;
			nxt_s.aw_idx  = s_axi_awaddr[8:2];
			nxt_s.aw_bad  = !addr_ok(s_axi_awaddr);
		end
		if (w_fire)
		begin
			nxt_s.w_hold  = 1'b1;
			nxt_s.w_byte  = s_axi_wdata[7:0];
			nxt_s.w_lane0 = s_axi_wstrb[0];
		end
		if (s_ff.bvalid && s_axi_bready)
			nxt_s.bvalid = 1'b0;
		// address and data may come in either order; act in the cycle the second one is accepted
		if (have_aw && have_w)
		begin
			nxt_s.aw_hold = 1'b0;
			nxt_s.w_hold  = 1'b0;
			nxt_s.bvalid  = 1'b1;
			nxt_s.bresp   = wr_ok ? fch_pkg::RESP_OKAY : fch_pkg::RESP_SLVERR;
			if (wr_ok && wl)
			begin
				unique case (wr_idx)
					// R7: channel select lives in main bit 6
					fch_pkg::IDX_MAIN: nxt_s.main_reg = wb;
					fch_pkg::IDX_INTF: nxt_s.intf_reg = wb;
					fch_pkg::IDX_LOCK: nxt_s.lock_reg = wb;
					// R6: either set is writable whichever one is selected
					fch_pkg::IDX_FA2: nxt_s.channel_freq_set_first[23:16] = wb;
					fch_pkg::IDX_FA1: nxt_s.channel_freq_set_first[15:8] = wb;
					fch_pkg::IDX_FA0: nxt_s.channel_freq_set_first[7:0] = wb;
					fch_pkg::IDX_FB2: nxt_s.channel_freq_set_second[23:16] = wb;
					fch_pkg::IDX_FB1: nxt_s.channel_freq_set_second[15:8] = wb;
					fch_pkg::IDX_FB0: nxt_s.channel_freq_set_second[7:0] = wb;
					// R8: forced values and their enables
					fch_pkg::IDX_OVR1: nxt_s.override_reg_one = wb;
					fch_pkg::IDX_OVR2: nxt_s.override_reg_two = wb;
					fch_pkg::IDX_OVR3: nxt_s.override_reg_three = wb;
					default: ;
				endcase
			end
		end
		if (s_ff.rvalid && s_axi_rready)
			nxt_s.rvalid = 1'b0;
		if (ar_fire)
		begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp  = addr_ok(s_axi_araddr) ? fch_pkg::RESP_OKAY
			                                     : fch_pkg::RESP_SLVERR;
			nxt_s.rdata  = 8'h00;
			if (addr_ok(s_axi_araddr))
			begin
				unique case (rd_idx)
					fch_pkg::IDX_MAIN: nxt_s.rdata = s_ff.main_reg;
					fch_pkg::IDX_INTF: nxt_s.rdata = s_ff.intf_reg;
					fch_pkg::IDX_LOCK: nxt_s.rdata = s_ff.lock_reg;
					fch_pkg::IDX_FA2:  nxt_s.rdata = s_ff.channel_freq_set_first[23:16];
					fch_pkg::IDX_FA1:  nxt_s.rdata = s_ff.channel_freq_set_first[15:8];
					fch_pkg::IDX_FA0:  nxt_s.rdata = s_ff.channel_freq_set_first[7:0];
					fch_pkg::IDX_FB2:  nxt_s.rdata = s_ff.channel_freq_set_second[23:16];
					fch_pkg::IDX_FB1:  nxt_s.rdata = s_ff.channel_freq_set_second[15:8];
					fch_pkg::IDX_FB0:  nxt_s.rdata = s_ff.channel_freq_set_second[7:0];
					fch_pkg::IDX_OVR1: nxt_s.rdata = s_ff.override_reg_one;
					fch_pkg::IDX_OVR2: nxt_s.rdata = s_ff.override_reg_two;
					fch_pkg::IDX_OVR3: nxt_s.rdata = s_ff.override_reg_three;
					// R9: raw results the host saves per channel
					fch_pkg::IDX_RES1: nxt_s.rdata = {4'h0, cal_result_in.pump_current};
					fch_pkg::IDX_RES2: nxt_s.rdata = {3'h0, cal_result_in.osc_array};
					fch_pkg::IDX_RES3: nxt_s.rdata = {2'h0, cal_result_in.osc_cal_current};
					default: ;
				endcase
			end
		end
		// lock level counts only once the last two stages agree
		nxt_s.lock_sync = {s_ff.lock_sync[1:0], pll_lock_in};
		if (s_ff.lock_sync[1] == s_ff.lock_sync[2])
			nxt_s.lock_filt = s_ff.lock_sync[2];
		// R1: polarity sets the active level
		// R2: tx pin follows the internal power amplifier
		// R4: with follow clear the pin just shows its polarity bit
		nxt_s.amp_o = (s_ff.intf_reg[fch_pkg::TX_FOLLOW_BIT] && !int_pa_on) ? !tx_pol
		                                                                     : tx_pol;
		// R3: rx pin follows the internal low-noise amplifier
		nxt_s.rx_amp_o = (s_ff.intf_reg[fch_pkg::RX_FOLLOW_BIT] && !int_lna_on) ? !rx_pol
		                                                                         : rx_pol;
		// R5: constant levels, or the filtered lock for the lock code
		unique case (s_ff.lock_reg[3:0])
			fch_pkg::LSEL_LOW:  nxt_s.lock_o = 1'b0;
			fch_pkg::LSEL_HIGH: nxt_s.lock_o = 1'b1;
			fch_pkg::LSEL_LOCK: nxt_s.lock_o = s_ff.lock_filt;
			default:            nxt_s.lock_o = 1'b0;
		endcase
		// R7: active set chosen by the channel select bit
		nxt_s.synth.freq = s_ff.main_reg[fch_pkg::MAIN_CHAN_SEL] ?
		                   s_ff.channel_freq_set_second : s_ff.channel_freq_set_first;
		// R14: forced values replace calibration results while enabled
		nxt_s.synth.cal.osc_array = s_ff.override_reg_two[fch_pkg::OSC_ARR_EN_BIT] ?
		                            s_ff.override_reg_two[4:0] : cal_result_in.osc_array;
		nxt_s.synth.cal.pump_current = s_ff.override_reg_two[fch_pkg::PUMP_EN_BIT] ?
		                               s_ff.override_reg_one[3:0] : cal_result_in.pump_current;
		nxt_s.synth.cal.osc_cal_current = s_ff.override_reg_three[fch_pkg::OSC_CAL_EN_BIT] ?
		                                  s_ff.override_reg_three[5:0]
		                                  : cal_result_in.osc_cal_current;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s_ff <= '0;
			s_ff.main_reg <= fch_pkg::REG_RST;
		end
		else
			s_ff <= nxt_s;
	end

	assign s_axi_bvalid          = s_ff.bvalid;
	assign s_axi_bresp           = s_ff.bresp;
	assign s_axi_rvalid          = s_ff.rvalid;
	assign s_axi_rresp           = s_ff.rresp;
	assign s_axi_rdata           = {24'h000000, s_ff.rdata};
	assign ext_amp_enable_out    = s_ff.amp_o;
	assign ext_rx_amp_enable_out = s_ff.rx_amp_o;
	assign lock_out              = s_ff.lock_o;
	assign synth_ctrl            = s_ff.synth;

	// --------------------------------
	// checks
	// --------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	tx_static_a: assert property ( // R4
		!s_ff.intf_reg[fch_pkg::TX_FOLLOW_BIT] && $stable(s_ff.intf_reg)
		|=> ext_amp_enable_out == $past(s_ff.intf_reg[fch_pkg::TX_POL_BIT]))
		else $error("tx enable pin not static at polarity bit");
	tx_follow_a: assert property ( // R2
		s_ff.intf_reg[fch_pkg::TX_FOLLOW_BIT] && int_pa_on
		|=> ext_amp_enable_out == $past(s_ff.intf_reg[fch_pkg::TX_POL_BIT]))
		else $error("tx enable pin not active while amplifier on");
	rx_follow_a: assert property ( // R3
		s_ff.intf_reg[fch_pkg::RX_FOLLOW_BIT] && !int_lna_on
		|=> ext_rx_amp_enable_out != $past(s_ff.intf_reg[fch_pkg::RX_POL_BIT]))
		else $error("rx enable pin active while amplifier off");
	lock_low_a: assert property ( // R5
		s_ff.lock_reg[3:0] == fch_pkg::LSEL_LOW |=> !lock_out)
		else $error("lock pin not low for select zero");
	lock_high_a: assert property ( // R5
		s_ff.lock_reg[3:0] == fch_pkg::LSEL_HIGH |=> lock_out)
		else $error("lock pin not high for select one");
	first_set_a: assert property ( // R6
		!s_ff.main_reg[fch_pkg::MAIN_CHAN_SEL]
		|=> synth_ctrl.freq == $past(s_ff.channel_freq_set_first))
		else $error("first set not driving synthesizer");
	hop_switch_a: assert property ( // R7
		$rose(s_ff.main_reg[fch_pkg::MAIN_CHAN_SEL])
		|=> synth_ctrl.freq == $past(s_ff.channel_freq_set_second))
		else $error("hop did not switch to second set");
	osc_force_a: assert property ( // R14
		s_ff.override_reg_two[fch_pkg::OSC_ARR_EN_BIT]
		|=> synth_ctrl.cal.osc_array == $past(s_ff.override_reg_two[4:0]))
		else $error("forced oscillator array not applied");
	pump_free_a: assert property ( // R14
		!s_ff.override_reg_two[fch_pkg::PUMP_EN_BIT]
		|=> synth_ctrl.cal.pump_current == $past(cal_result_in.pump_current))
		else $error("pump current not from calibration");
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	hop_seen_c: cover property ($rose(s_ff.main_reg[fch_pkg::MAIN_CHAN_SEL]));
	force_all_c: cover property (s_ff.override_reg_two[fch_pkg::OSC_ARR_EN_BIT]
		&& s_ff.override_reg_two[fch_pkg::PUMP_EN_BIT]
		&& s_ff.override_reg_three[fch_pkg::OSC_CAL_EN_BIT]);
	lock_pin_c: cover property (s_ff.lock_reg[3:0] == fch_pkg::LSEL_LOCK && lock_out);
endmodule

// File: verification/fch_frontend_model.sv
// external amplifier or t/r switch hanging on the two enable pins
// assumes the bench tells it which level switches each stage on
`timescale 1ns/10ps
module fch_frontend_model (
	input  wire logic tx_en_pin,   // tx amp enable pin
	input  wire logic rx_en_pin,   // rx amp enable pin
	input  wire logic tx_act_high, // tx stage wants a high level
	input  wire logic rx_act_high, // rx stage wants a high level
	output logic      tx_path_on,  // external tx stage powered
	output logic      rx_path_on   // external rx stage powered
);
	assign tx_path_on = (tx_en_pin == tx_act_high);
	assign rx_path_on = (rx_en_pin == rx_act_high);
endmodule

// File: verification/fch_ctrl_test.sv
// self-checking bench for the front-end and hop control block
// assumes one 40 mhz clock and the axi4-lite map of fch_pkg
`timescale 1ns/10ps
module fch_ctrl_test;
	logic                ref_clk, rst, int_pa_on, int_lna_on, pll_lock_in;
	logic [11:0]         s_axi_awaddr, s_axi_araddr;
	logic                s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic                s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                s_axi_arready, s_axi_rvalid, ext_amp_enable_out;
	logic                ext_rx_amp_enable_out, lock_out, tx_on, rx_on, tx_pol, rx_pol;
	logic [31:0]         s_axi_wdata, s_axi_rdata;
	logic [3:0]          s_axi_wstrb;
	logic [1:0]          s_axi_bresp, s_axi_rresp;
	fch_pkg::fch_cal_t   cal_result_in, keep;
	fch_pkg::fch_synth_t synth_ctrl;
	logic [33:0]         exq[$];
	logic [23:0]         fa, fb;
	int                  fails, n_compared, i;
	integer              seed;
	fch_ctrl u_fch_ctrl (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .int_pa_on, .int_lna_on,
		.pll_lock_in, .cal_result_in, .ext_amp_enable_out, .ext_rx_amp_enable_out,
		.lock_out, .synth_ctrl);
	fch_frontend_model u_fch_frontend_model (.tx_en_pin(ext_amp_enable_out),
		.rx_en_pin(ext_rx_amp_enable_out), .tx_act_high(tx_pol), .rx_act_high(rx_pol),
		.tx_path_on(tx_on), .rx_path_on(rx_on));
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// --------------------------------
	// reporting and bus tasks
	// --------------------------------
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task tally(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cmp_bus(input logic [33:0] got, input logic [33:0] exp);
		tally({6'h0, got}, {6'h0, exp});
	endtask
	task cmp_pin(input logic [39:0] got, input logic [39:0] exp);
		tally(got, exp);
	endtask
	task hang;
		fails++;
		close_out();
	endtask
	task settle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// bready and rready stay high, so a response is taken at the edge it shows
	task wr(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] rsp);
		int k;
		exq.push_back({rsp, 32'h0});
		s_axi_awaddr <= {3'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (k = 0; k < 40; k++)
		begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		if (k == 40)
			hang();
	endtask
	task rd(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] rsp);
		int k;
		exq.push_back({rsp, 24'h0, d});
		s_axi_araddr <= {3'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		for (k = 0; k < 40; k++)
		begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		if (k == 40)
			hang();
	endtask
	task wset(input logic [6:0] base, input logic [23:0] f);
		wr(base, f[23:16], fch_pkg::RESP_OKAY);
		wr(base + 7'h1, f[15:8], fch_pkg::RESP_OKAY);
		wr(base + 7'h2, f[7:0], fch_pkg::RESP_OKAY);
	endtask
	always @(posedge ref_clk)
	begin
		if (s_axi_rvalid && s_axi_rready)
			cmp_bus({s_axi_rresp, s_axi_rdata}, exq.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			cmp_bus({s_axi_bresp, 32'h0}, exq.pop_front());
	end
	// --------------------------------
	// main sequence
	// --------------------------------
	initial
	begin
		seed = 32'h54d5;
		{rst, s_axi_bready, s_axi_rready} = 3'h7;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, int_pa_on, int_lna_on} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		{s_axi_wstrb, pll_lock_in, tx_pol, rx_pol} = 7'h78;
		cal_result_in = 15'h0;
		settle(8);
		rst <= 1'b0;
		cmp_pin({lock_out, ext_rx_amp_enable_out, ext_amp_enable_out}, 40'h0);
		rd(fch_pkg::IDX_INTF, 8'h00, fch_pkg::RESP_OKAY);
		for (i = 0; i < 4; i++)
		begin
			wr(fch_pkg::IDX_INTF, i[7:0], fch_pkg::RESP_OKAY);
			{int_pa_on, int_lna_on} <= 2'($random(seed));
			settle(3);
			cmp_pin({ext_rx_amp_enable_out, ext_amp_enable_out}, i[1:0]);
		end
		for (i = 0; i < 16; i++)
		begin
			{rx_pol, tx_pol} <= i[1:0];
			wr(fch_pkg::IDX_INTF, {6'h3, i[1:0]}, fch_pkg::RESP_OKAY);
			{int_pa_on, int_lna_on} <= 2'($random(seed));
			settle(3);
			cmp_pin({rx_on, tx_on}, {int_lna_on, int_pa_on});
		end
		pll_lock_in <= 1'b1;
		for (i = 3; i >= 0; i--)
		begin
			wr(fch_pkg::IDX_LOCK, i[7:0], fch_pkg::RESP_OKAY);
			settle(8);
			cmp_pin(lock_out, (i == 1 || i == 2));
		end
		fa = 24'($random(seed));
		fb = 24'($random(seed));
		wset(fch_pkg::IDX_FA2, fa);
		wset(fch_pkg::IDX_FB2, fb);
		settle(3);
		cmp_pin(synth_ctrl.freq, fa);
		wr(fch_pkg::IDX_MAIN, 8'h40, fch_pkg::RESP_OKAY);
		settle(3);
		cmp_pin(synth_ctrl.freq, fb);
		fa = 24'($random(seed));
		wset(fch_pkg::IDX_FA2, fa);
		settle(3);
		cmp_pin(synth_ctrl.freq, fb);
		// calibrate then hop with stored values
		cal_result_in <= 15'($random(seed));
		settle(3);
		cmp_pin(synth_ctrl, {fb, cal_result_in});
		keep = cal_result_in;
		rd(fch_pkg::IDX_RES1, {4'h0, keep.pump_current}, fch_pkg::RESP_OKAY);
		rd(fch_pkg::IDX_RES2, {3'h0, keep.osc_array}, fch_pkg::RESP_OKAY);
		rd(fch_pkg::IDX_RES3, {2'h0, keep.osc_cal_current}, fch_pkg::RESP_OKAY);
		cal_result_in <= ~keep;
		int_pa_on <= 1'b0;
		wr(fch_pkg::IDX_MAIN, 8'h00, fch_pkg::RESP_OKAY);
		wr(fch_pkg::IDX_OVR1, {4'h0, keep.pump_current}, fch_pkg::RESP_OKAY);
		wr(fch_pkg::IDX_OVR2, {3'h2, keep.osc_array}, fch_pkg::RESP_OKAY);
		settle(3);
		cmp_pin(synth_ctrl, {fa, keep.pump_current, ~keep[10:0]});
		cmp_pin(ext_amp_enable_out, 1'b0);
		wr(fch_pkg::IDX_OVR2, {3'h3, keep.osc_array}, fch_pkg::RESP_OKAY);
		wr(fch_pkg::IDX_OVR3, {2'h1, keep.osc_cal_current}, fch_pkg::RESP_OKAY);
		wr(fch_pkg::IDX_LOCK, {4'h0, fch_pkg::LSEL_LOCK}, fch_pkg::RESP_OKAY);
		settle(3);
		cmp_pin(synth_ctrl, {fa, keep});
		cmp_pin(lock_out, 1'b1);
		int_pa_on <= 1'b1;
		// release overrides before a new calibration
		wr(fch_pkg::IDX_OVR2, 8'h00, fch_pkg::RESP_OKAY);
		wr(fch_pkg::IDX_OVR3, 8'h00, fch_pkg::RESP_OKAY);
		settle(3);
		cmp_pin(synth_ctrl, {fa, ~keep});
		cmp_pin(ext_amp_enable_out, 1'b1);
		// unmapped and read-only places
		wr(7'h30, 8'hff, fch_pkg::RESP_SLVERR);
		rd(7'h30, 8'h00, fch_pkg::RESP_SLVERR);
		wr(fch_pkg::IDX_RES1, 8'h0f, fch_pkg::RESP_OKAY);
		rd(fch_pkg::IDX_RES1, {4'h0, ~keep.pump_current}, fch_pkg::RESP_OKAY);
		settle(4);
		close_out();
	end
endmodule
